// ---- common/gl_pkg.sv ----
// What this block does
// - The lock control level locks or unlocks the guard, with its sense set by the build.
// - In the unlock-sensitive build, unlocking drops both safety outputs and relocking restores them.
// - In the open-sensitive build, only opening the guard drops the safety outputs.
// - Green shows supply, yellow shows the operating state and red shows faults by flash codes.
// - With a safety input missing, green flashes at 1 Hz, red is off, yellow follows the guard.
// - An internal error drops the outputs and clears only after fault removal and open-reclose.
// - A fault warning pulls the diagnostic output low, keeps the outputs, and clears by itself.
// - A warning that lasts 30 minutes also drops both safety outputs with red still flashing.
// - The diagnostic output is high when closed and lockable or locked, otherwise low.
// - An output 1 or output 2 fault shows one or two red pulses and is a 30 minute warning.
// - A cross-connection or both outputs faulty shows three red pulses as a 30 minute warning.
// - Over-temperature shows four red pulses and is a 30 minute warning.
// - A wrong or defective actuator shows five red pulses and shuts down at once.
// - A rotary handle in a forbidden position shows six red pulses and shuts down at once.
package gl_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);
  localparam int PULSE_ON_MS = 200;
  localparam int PULSE_OFF_MS = 200;
  localparam int GROUP_GAP_MS = 1000;
  localparam int WARN_DELAY_MIN = 30;
  localparam int WARN_DELAY_MS = WARN_DELAY_MIN * 60 * 1000;

  // ----------------------------------------
  // widths and flash codes
  // ----------------------------------------
  localparam int TICK_W = 17;
  localparam int WARN_W = 21;
  localparam int PH_W = 10;
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT1 = 3'h1;
  localparam logic [2:0] CODE_OUT2 = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACT = 3'h5;
  localparam logic [2:0] CODE_HANDLE = 3'h6;
  localparam logic [2:0] CODE_STEADY = 3'h7;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic lock_ctrl;
    logic safety_input_1;
    logic safety_input_2;
    logic guard_closed;
    logic guard_locked;
    logic lock_possible;
    logic fault_out1;
    logic fault_out2;
    logic fault_cross;
    logic over_temp;
    logic actuator_bad;
    logic handle_bad;
    logic internal_error;
    logic power_to_lock;
    logic open_sensitive;
  } gl_pins_t;

  typedef struct packed {
    logic solenoid_on;
    logic lock_request;
    logic safety_output_1;
    logic safety_output_2;
    logic diag_out;
    logic led_green;
    logic led_yellow;
    logic led_red;
  } gl_outs_t;

  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} gl_flash_t;

endpackage

// ---- dv/gl_guard_lock_asserts.sv ----
`timescale 1ns/1ps
module gl_guard_lock_asserts
  import gl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire gl_pkg::gl_pins_t pins,
  input wire gl_pkg::gl_outs_t outs
);
  // ----------------------------------------
  // settle counter and checks
  // ----------------------------------------
  // past samples are trusted only once the sync chain holds post-reset values
  logic [2:0] cnt;
  logic ok;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= 3'h0;
    else if (cnt != 3'h7)
      cnt <= cnt + 3'h1;
  end
  assign ok = (cnt > 3'h4);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_in_ok;
    ok && $past(pins.safety_input_1, 3) && $past(pins.safety_input_2, 3);
  endsequence
  sequence s_err;
    s_in_ok ##0 $past(pins.internal_error, 3);
  endsequence
  a_solenoid_follow: assert property (ok |-> outs.solenoid_on == $past(pins.lock_ctrl, 3))
    else $error("solenoid does not follow lock control");
  a_lock_sense: assert property (ok |-> outs.lock_request == ($past(pins.power_to_lock, 3) ?
    $past(pins.lock_ctrl, 3) : !$past(pins.lock_ctrl, 3)))
    else $error("lock request has wrong sense");
  a_output_pair: assert property (ok |-> outs.safety_output_1 == outs.safety_output_2)
    else $error("safety outputs disagree");
  a_unlock_drop: assert property (ok && !$past(pins.open_sensitive, 3)
    && !$past(pins.guard_locked, 3) |-> !outs.safety_output_1)
    else $error("unlocked guard keeps outputs on");
  a_open_drop: assert property (ok && !$past(pins.guard_closed, 3)
    |-> !outs.safety_output_1 && !outs.diag_out)
    else $error("open guard keeps outputs on");
  a_missing_input: assert property (ok && !($past(pins.safety_input_1, 3)
    && $past(pins.safety_input_2, 3)) |-> !outs.led_red && !outs.safety_output_2)
    else $error("missing input not honoured");
  a_error_red: assert property (s_err |-> outs.led_red && !outs.safety_output_1
    && !outs.diag_out)
    else $error("internal error not shown");
  a_green_supply: assert property (s_in_ok |-> outs.led_green)
    else $error("green off with inputs present");
  a_warn_diag: assert property (ok && $past(pins.over_temp, 3) |-> !outs.diag_out)
    else $error("warning leaves diag high");
  a_instant_stop: assert property (ok && $past(pins.actuator_bad, 3) |-> !outs.safety_output_1)
    else $error("bad actuator keeps outputs on");
endmodule
bind gl_guard_lock gl_guard_lock_asserts u_gl_guard_lock_asserts (.clk(clk), .rst(rst),
  .pins(pins), .outs(outs));

// ---- dv/gl_guard_lock_tb_top.sv ----
`timescale 1ns/1ps
module gl_guard_lock_tb_top;
  import gl_pkg::*;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  // short tick keeps flash periods inside the run budget
  localparam int TL = 2;
  typedef struct packed {gl_pins_t p; logic [2:0] e;} gl_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gl_pins_t drv = '0;
  gl_pins_t pins;
  gl_outs_t outs;
  logic plc_lock;
  logic enabled;
  int mismatches = 0;
  int comparisons = 0;
  int r;
  // expected: safety output, diag, lock request
  gl_row_t rows [7] = '{'{15'h7200, 3'h1}, '{15'h3A00, 3'h2}, '{15'h3A03, 3'h6},
    '{15'h7801, 3'h5}, '{15'h7E02, 3'h7}, '{15'h7E22, 3'h5}, '{15'h6E00, 3'h3}};
  always #5 clk = ~clk;
  // the controller model owns the lock control level
  always_comb
  begin
    pins = drv;
    pins.lock_ctrl = plc_lock;
  end
  gl_guard_lock #(.TICK_LEN(TL), .WARN_LEN(20)) u_gl_guard_lock (.clk(clk), .rst(rst),
    .pins(pins), .outs(outs));
  gl_plc_model u_gl_plc_model (.clk(clk), .want_lock(drv.lock_ctrl),
    .power_to_lock(drv.power_to_lock), .outs(outs), .lock_ctrl(plc_lock), .enabled(enabled));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic check_n(input int got, input int exp);
    check(got == exp, 1'b1, "pulse count");
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_pins(input gl_pins_t v, input int n);
    @(posedge clk);
    drv <= v;
    wait_clk(n);
  endtask
  // counts rising edges of green (g=1) or red over cyc cycles
  task automatic rises(input logic g, input int cyc, output int k);
    logic last;
    k = 0;
    last = g ? outs.led_green : outs.led_red;
    repeat (cyc)
    begin
      wait_clk(1);
      if ((g ? outs.led_green : outs.led_red) === 1'b1 && last !== 1'b1)
        k++;
      last = g ? outs.led_green : outs.led_red;
    end
  endtask
  task automatic first_rise(input logic g, input int lim);
    r = 0;
    for (int i = 0; i < lim && r == 0; i++)
      rises(g, 1, r);
  endtask
  // clearing a latched fault needs the guard opened and reclosed
  task automatic reopen;
    set_pins(15'h3200, 10);
    set_pins(15'h3E00, 10);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    #700_000;
    mismatches++;
    $display("[ERR] %0t watchdog", $time);
    final_report;
  end
  initial
  begin
    wait_clk(19);
    check(outs === '0, 1'b1, "outputs in reset");
    @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      set_pins(rows[i].p, 7);
      check(outs.safety_output_1, rows[i].e[2], "safety output");
      check(outs.diag_out, rows[i].e[1], "diag output");
      check(outs.lock_request, rows[i].e[0], "lock request");
      check(enabled, rows[i].e[2], "monitor view");
      $display("row %0d done", i);
    end
    set_pins(15'h1E00, 5);
    check(outs.led_yellow, 1'b1, "yellow locked");
    first_rise(1'b1, 2100);
    rises(1'b1, 3000, r);
    check_n(r, 1);
    $display("blink test done");
    set_pins(15'h3E20, 20);
    check(outs.safety_output_1, 1'b1, "warning keeps output");
    wait_clk(60);
    check(outs.safety_output_1, 1'b0, "warning trip");
    reopen;
    check(outs.safety_output_1, 1'b1, "trip cleared");
    set_pins(15'h3E04, 10);
    check(outs.led_red, 1'b1, "steady red");
    set_pins(15'h3E00, 10);
    check(outs.safety_output_1, 1'b0, "error latched");
    reopen;
    check(outs.safety_output_1, 1'b1, "error cleared");
    $display("fault test done");
    for (int n = 1; n <= 6; n++)
    begin
      set_pins(15'h3E00 | (15'h0100 >> (n - 1)), 1);
      first_rise(1'b0, (400 * n + 811) * TL);
      rises(1'b0, (400 * n + 400) * TL, r);
      check_n(r, n - 1);
      check(outs.safety_output_1, 1'b0, "shutdown");
      reopen;
      $display("code %0d done", n);
    end
    final_report;
  end
endmodule

// ---- dv/gl_plc_model.sv ----
`timescale 1ns/1ps
module gl_plc_model
  import gl_pkg::*;
(
  // clock
  input wire logic clk,
  // commands from the test
  input wire logic want_lock,
  input wire logic power_to_lock,
  // device side
  input wire gl_pkg::gl_outs_t outs,
  output logic lock_ctrl = 1'b0,
  output logic enabled = 1'b0
);
  // ----------------------------------------
  // controller and monitor
  // ----------------------------------------
  // the level meaning lock depends on the build; monitor needs both channels
  always @(posedge clk)
  begin
    lock_ctrl <= power_to_lock ? want_lock : !want_lock;
    enabled <= outs.safety_output_1 && outs.safety_output_2;
  end
endmodule

// ---- src/gl_guard_lock.sv ----
`timescale 1ns/1ps
module gl_guard_lock #(
  parameter int TICK_LEN = gl_pkg::TICK_CYCLES,
  parameter int WARN_LEN = gl_pkg::WARN_DELAY_MS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and straps from outside, asynchronous
  input wire gl_pkg::gl_pins_t pins,
  // pins to the outside
  output gl_pkg::gl_outs_t outs
);
  import gl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    gl_pins_t sync1;
    gl_pins_t sync2;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [PH_W-1:0] blink_cnt;
    logic blink;
    logic [WARN_W-1:0] warn_cnt;
    logic warn_trip;
    logic err_latch;
    logic err_opened;
    logic [2:0] shown_code;
    gl_flash_t flash;
    logic [PH_W-1:0] ph_cnt;
    logic [2:0] pulse_n;
    gl_outs_t outs;
  } gl_state_t;

  gl_state_t s;
  gl_state_t next_s;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
  localparam logic [WARN_W-1:0] WARN_LAST = WARN_W'(WARN_LEN - 1);
  localparam logic [PH_W-1:0] BLINK_LAST = PH_W'(BLINK_HALF_MS - 1);
  localparam logic [PH_W-1:0] ON_LAST = PH_W'(PULSE_ON_MS - 1);
  localparam logic [PH_W-1:0] OFF_LAST = PH_W'(PULSE_OFF_MS - 1);
  localparam logic [PH_W-1:0] GAP_LAST = PH_W'(GROUP_GAP_MS - 1);

  gl_pins_t p;
  logic inputs_ok;
  logic locked;
  logic warn_active;
  logic shut_cause;
  logic [2:0] cur_code;
  logic enable_base;
  logic err_any;
  logic red_pulse;

  // ----------------------------------------
  // condition decode
  // ----------------------------------------
  // everything below reads only the second synchroniser stage
  always_comb
  begin
    p = s.sync2;
    inputs_ok = p.safety_input_1 & p.safety_input_2;
    locked = p.guard_closed & p.guard_locked;
    warn_active = p.fault_out1 | p.fault_out2 | p.fault_cross | p.over_temp;
    shut_cause = p.internal_error | p.actuator_bad | p.handle_bad;
    // most severe cause picks the code; both outputs bad reads as a cross fault
    if (p.internal_error)
      cur_code = CODE_STEADY;
    else if (p.handle_bad)
      cur_code = CODE_HANDLE;
    else if (p.actuator_bad)
      cur_code = CODE_ACT;
    else if (p.over_temp)
      cur_code = CODE_TEMP;
    else if (p.fault_cross | (p.fault_out1 & p.fault_out2))
      cur_code = CODE_CROSS;
    else if (p.fault_out2)
      cur_code = CODE_OUT2;
    else if (p.fault_out1)
      cur_code = CODE_OUT1;
    else
      cur_code = CODE_NONE;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;

    // millisecond tick; long counts run on it to keep counters narrow
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST)
    begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.tick_cnt = s.tick_cnt + 1'b1;

    // 1 Hz blink, half period on and half off
    if (s.tick)
    begin
      if (s.blink_cnt == BLINK_LAST)
      begin
        next_s.blink_cnt = '0;
        next_s.blink = ~s.blink;
      end
      else
        next_s.blink_cnt = s.blink_cnt + 1'b1;
    end

    // warning timer restarts whenever the cause goes away
    if (!warn_active)
      next_s.warn_cnt = '0;
    else if (s.tick && !s.warn_trip)
    begin
      if (s.warn_cnt == WARN_LAST)
      begin
        // latch together with the trip, so the clear path below can always release it
        next_s.warn_trip = 1'b1;
        next_s.err_latch = 1'b1;
      end
      else
        next_s.warn_cnt = s.warn_cnt + 1'b1;
    end

    // error latch: a live cause always wins over the clear
    // an opening counts only once every cause has gone
    if (s.err_latch && !p.guard_closed && !shut_cause && !warn_active)
      next_s.err_opened = 1'b1;
    if (shut_cause)
      next_s.err_latch = 1'b1;
    else if (s.err_latch && s.err_opened && p.guard_closed && !warn_active)
    begin
      next_s.err_latch = 1'b0;
      next_s.err_opened = 1'b0;
      next_s.warn_trip = 1'b0;
    end

    // keep the last code shown while an error is held
    if (cur_code != CODE_NONE)
      next_s.shown_code = cur_code;
    else if (!s.err_latch)
      next_s.shown_code = CODE_NONE;

    // flash groups: n pulses then a long gap, repeated
    if (s.tick)
    begin
      next_s.ph_cnt = s.ph_cnt + 1'b1;
      case (s.flash)
        FL_IDLE:
        begin
          next_s.ph_cnt = '0;
          if (s.shown_code != CODE_NONE && s.shown_code != CODE_STEADY)
          begin
            next_s.flash = FL_ON;
            next_s.pulse_n = 3'h1;
          end
        end
        FL_ON:
          if (s.ph_cnt == ON_LAST)
          begin
            next_s.ph_cnt = '0;
            if (s.pulse_n >= s.shown_code)
              next_s.flash = FL_GAP;
            else
              next_s.flash = FL_OFF;
          end
        FL_OFF:
          if (s.ph_cnt == OFF_LAST)
          begin
            next_s.ph_cnt = '0;
            next_s.flash = FL_ON;
            next_s.pulse_n = s.pulse_n + 1'b1;
          end
        FL_GAP:
          if (s.ph_cnt == GAP_LAST)
          begin
            next_s.ph_cnt = '0;
            next_s.flash = FL_IDLE;
          end
        default:
          next_s.flash = FL_IDLE;
      endcase
    end

    // ----------------------------------------
    // outputs, registered
    // ----------------------------------------
    // magnet follows the input level; its meaning depends on the build
    next_s.outs.solenoid_on = p.lock_ctrl;
    next_s.outs.lock_request = p.power_to_lock ? p.lock_ctrl : ~p.lock_ctrl;

    // unlock-sensitive needs the lock, open-sensitive only a closed guard
    next_s.outs.safety_output_1 = enable_base;
    next_s.outs.safety_output_2 = enable_base;

    // warnings pull diag low; the outputs drop only once the warning timer trips
    next_s.outs.diag_out = p.guard_closed & (locked | p.lock_possible)
                           & ~warn_active & ~err_any;

    next_s.outs.led_green = inputs_ok ? 1'b1 : s.blink;
    if (err_any && inputs_ok)
      next_s.outs.led_yellow = 1'b0;
    else if (locked)
      next_s.outs.led_yellow = 1'b1;
    else if (p.guard_closed)
      next_s.outs.led_yellow = s.blink;
    else
      next_s.outs.led_yellow = 1'b0;
    // red stays dark while a safety input is missing
    if (!inputs_ok)
      next_s.outs.led_red = 1'b0;
    // the code taken this cycle, so steady red comes with the output drop
    else if (next_s.shown_code == CODE_STEADY)
      next_s.outs.led_red = 1'b1;
    else
      next_s.outs.led_red = red_pulse;
  end

  // ----------------------------------------
  // output gating helpers
  // ----------------------------------------
  assign err_any = s.err_latch | shut_cause | s.warn_trip;
  assign red_pulse = (s.flash == FL_ON);
  // closed-unlocked keeps outputs only for the open-sensitive build
  assign enable_base = inputs_ok & ~err_any
                       & (p.open_sensitive ? p.guard_closed : locked);

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign outs = s.outs;

endmodule
